// ### rtl/cmp_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmp_defines.vh"

// One comparator channel: synchroniser, noise filter and edge detector.
module cmp_channel (
  input wire clock,
  input wire rstn,
  input wire enable,
  input wire raw_result,
  input wire [1:0] filter_select,
  input wire [1:0] edge_select,
  output reg filtered,
  output reg edge_pulse
);

  reg [2:0] sync;
  reg [7:0] count;
  reg [2:0] samples;
  reg stable_in;
  reg sample_tick;
  reg next_filtered;

  always @* begin
    case (filter_select)
      2'h1: sample_tick = (count == (`FILTER_PERIOD1 - 1));
      2'h2: sample_tick = (count == (`FILTER_PERIOD2 - 1));
      2'h3: sample_tick = (count == (`FILTER_PERIOD3 - 1));
      default: sample_tick = 1'b1;
    endcase
  end

  // Four equal samples (three held plus the current level) pass when filtering; bypass passes the synchronised level.
  always @* begin
    next_filtered = filtered;
    if (filter_select == 2'h0) begin
      next_filtered = stable_in;
    end else if (sample_tick) begin
      if (samples[1:0] == {2{stable_in}} && samples[2] == stable_in) begin
        next_filtered = stable_in;
      end
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync <= 3'h0;
      stable_in <= 1'b0;
      count <= 8'h00;
      samples <= 3'h0;
      filtered <= 1'b0;
      edge_pulse <= 1'b0;
    end else if (enable) begin
      sync[0] <= raw_result;
      sync[1] <= sync[0];
      sync[2] <= sync[1];
      // A change counts once the second and third stages agree.
      if (sync[1] == sync[2]) begin
        stable_in <= sync[2];
      end
      count <= (sample_tick || filter_select == 2'h0) ? 8'h00 : count + 8'h01;
      if (sample_tick) begin
        samples <= {samples[1:0], stable_in};
      end
      filtered <= next_filtered;
      // Compare the new filtered value with the held one.
      edge_pulse <= ((next_filtered && !filtered && edge_select[0]) ||
                     (!next_filtered && filtered && edge_select[1]));
    end else begin
      edge_pulse <= 1'b0;
    end
  end

endmodule // cmp_channel

`default_nettype wire

// ### rtl/dac_cmp_defines.vh
`ifndef DAC_CMP_DEFINES_VH
`define DAC_CMP_DEFINES_VH

// Register offsets on the plain register port.
`define REG_INPUT_SELECT 4'h0
`define REG_REFERENCE_SELECT 4'h1
`define REG_CMP_CONTROL 4'h2
`define REG_CMP_RESULT 4'h3
`define REG_DAC_CONTROL 4'h4
`define REG_DAC_DESTINATION 4'h5
`define REG_DAC_DATA0 4'h6
`define REG_DAC_DATA1 4'h7
`define REG_STOP_CONTROL 4'h8

// Field positions.
`define CTL_FILTER_LSB 0
`define CTL_EDGE_LSB 2
`define CTL_OUT_EN_BIT 4
`define DAC_CONTROL_REGISTER_ENABLE0_BIT 0
`define DAC_CONTROL_REGISTER_ENABLE1_BIT 1
`define DAC_CONTROL_REGISTER_EVENT_EN_BIT 2
`define DSEL_PIN0_BIT 0
`define DSEL_PIN1_BIT 1
`define DSEL_CMP0_BIT 2
`define DSEL_CMP1_BIT 3
`define STOP_CMP_BIT 0
`define STOP_DAC_BIT 1

// Edge selection codes.
`define EDGE_RISING 2'h1
`define EDGE_FALLING 2'h2
`define EDGE_BOTH 2'h3

// Reset values.
`define RESET_SELECT 8'h00
`define RESET_CONTROL 8'h00
`define RESET_STOP 8'h03

// Filter sampling periods in clock cycles.
`define FILTER_PERIOD1 8
`define FILTER_PERIOD2 32
`define FILTER_PERIOD3 128

`endif

// ### rtl/dac_comparator_control.v
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmp_defines.vh"

module dac_comparator_control #(
  parameter CHANNELS = 6,
  parameter DAC_BITS = 12
) (
  input wire clock,
  input wire rstn,
  input wire clock_enable,
  input wire [3:0] address,
  input wire [15:0] write_data,
  input wire write_strobe,
  input wire read_strobe,
  output reg [15:0] read_data,
  input wire [CHANNELS-1:0] raw_result,
  input wire adc_stopped,
  input wire adc_sync_enable,
  input wire routed_event,
  output reg [4*CHANNELS-1:0] input_connect,
  output reg [4*CHANNELS-1:0] reference_connect,
  output wire [CHANNELS-1:0] interrupt_request,
  output wire [CHANNELS-1:0] event_output,
  output wire [CHANNELS-1:0] output_enable_source,
  output reg [CHANNELS-1:0] result_pin,
  output reg [CHANNELS-1:0] result_pin_enable,
  output reg [DAC_BITS-1:0] dac_output0,
  output reg [DAC_BITS-1:0] dac_output1,
  output reg dac_pin_enable0,
  output reg dac_pin_enable1,
  output reg dac_cmp_enable0,
  output reg dac_cmp_enable1,
  output reg dac_convert0
);

  // Selection fields, stored as written, four bits per channel; decoded to one-hot on the connect outputs.
  reg [4*CHANNELS-1:0] input_select_field;
  reg [4*CHANNELS-1:0] reference_select_field;
  reg [5*CHANNELS-1:0] channel_control;
  reg [2:0] dac_control_register;
  reg [3:0] dac_destination_register;
  reg [DAC_BITS-1:0] dac_data0;
  reg [DAC_BITS-1:0] dac_data1;
  reg pending0;
  reg pending1;
  reg event_pending;
  reg [1:0] stop_control;
  integer sel_channel;
  wire [CHANNELS-1:0] filtered;
  wire [CHANNELS-1:0] edge_pulse;
  wire [CHANNELS-1:0] channel_valid;
  wire cmp_run;
  wire dac_run;

  assign cmp_run = clock_enable && !stop_control[`STOP_CMP_BIT];
  assign dac_run = clock_enable && !stop_control[`STOP_DAC_BIT];

  // Keeps only the documented codes; any other code connects nothing.
  function [3:0] one_hot;
    input [3:0] code;
    begin
      case (code)
        4'h1, 4'h2, 4'h4, 4'h8: one_hot = code;
        default: one_hot = 4'h0;
      endcase
    end
  endfunction

  // A channel that selects an amplified input is invalid while A/D is stopped.
  function amplified;
    input integer channel;
    input [3:0] code;
    begin
      amplified = (channel < 3) && (code == 4'h1);
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : gen_channel
      cmp_channel u_channel (
        .clock(clock),
        .rstn(rstn),
        .enable(cmp_run),
        .raw_result(raw_result[gi]),
        .filter_select(channel_control[5*gi+`CTL_FILTER_LSB +: 2]),
        .edge_select(channel_control[5*gi+`CTL_EDGE_LSB +: 2]),
        .filtered(filtered[gi]),
        .edge_pulse(edge_pulse[gi])
      );
      assign channel_valid[gi] = !(adc_stopped &&
        amplified(gi, input_select_field[4*gi +: 4]));
      assign interrupt_request[gi] = edge_pulse[gi] && channel_valid[gi];
      assign event_output[gi] = filtered[gi] && channel_valid[gi];
      assign output_enable_source[gi] = filtered[gi] && channel_valid[gi];
    end
  endgenerate

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      input_connect <= {4*CHANNELS{1'b0}};
      reference_connect <= {4*CHANNELS{1'b0}};
      result_pin <= {CHANNELS{1'b0}};
      result_pin_enable <= {CHANNELS{1'b0}};
    end else if (clock_enable) begin
      for (sel_channel = 0; sel_channel < CHANNELS; sel_channel = sel_channel + 1) begin
        input_connect[4*sel_channel +: 4] <=
          one_hot(input_select_field[4*sel_channel +: 4]);
        reference_connect[4*sel_channel +: 4] <=
          one_hot(reference_select_field[4*sel_channel +: 4]);
        result_pin[sel_channel] <= filtered[sel_channel] && channel_valid[sel_channel];
        result_pin_enable[sel_channel] <=
          channel_control[5*sel_channel+`CTL_OUT_EN_BIT] && cmp_run;
      end
    end
  end

  // Register writes, and the converter's deferred update.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      input_select_field <= {4*CHANNELS{1'b0}};
      reference_select_field <= {4*CHANNELS{1'b0}};
      channel_control <= {5*CHANNELS{1'b0}};
      dac_control_register <= 3'h0;
      dac_destination_register <= 4'h0;
      dac_data0 <= {DAC_BITS{1'b0}};
      dac_data1 <= {DAC_BITS{1'b0}};
      stop_control <= 2'h3;
      pending0 <= 1'b0;
      pending1 <= 1'b0;
      event_pending <= 1'b0;
      dac_output0 <= {DAC_BITS{1'b0}};
      dac_output1 <= {DAC_BITS{1'b0}};
      dac_convert0 <= 1'b0;
    end else if (clock_enable) begin
      dac_convert0 <= 1'b0;
      if (write_strobe) begin
        case (address)
          `REG_INPUT_SELECT: input_select_field <= {{(4*CHANNELS-16){1'b0}}, write_data};
          `REG_REFERENCE_SELECT: reference_select_field <=
            {{(4*CHANNELS-16){1'b0}}, write_data};
          `REG_CMP_CONTROL: begin
            if (write_data[15:13] < CHANNELS) begin
              channel_control[5*write_data[15:13] +: 5] <= write_data[4:0];
            end
          end
          `REG_DAC_CONTROL: dac_control_register <= write_data[2:0];
          `REG_DAC_DESTINATION: dac_destination_register <= write_data[3:0];
          `REG_DAC_DATA0: begin
            dac_data0 <= write_data[DAC_BITS-1:0];
            pending0 <= 1'b1;
          end
          `REG_DAC_DATA1: begin
            dac_data1 <= write_data[DAC_BITS-1:0];
            pending1 <= 1'b1;
          end
          `REG_STOP_CONTROL: stop_control <= write_data[1:0];
          default: ;
        endcase
      end
      if (dac_run) begin
        if (routed_event && dac_control_register[`DAC_CONTROL_REGISTER_EVENT_EN_BIT]) begin
          event_pending <= 1'b1;
        end
        if (adc_sync_enable) begin
          if (pending0 || event_pending) begin
            dac_output0 <= dac_data0;
            dac_convert0 <= dac_control_register[`DAC_CONTROL_REGISTER_ENABLE0_BIT];
            // A fresh event in the same cycle stays pending.
            if (!(routed_event && dac_control_register[`DAC_CONTROL_REGISTER_EVENT_EN_BIT])) begin
              event_pending <= 1'b0;
            end
            if (!(write_strobe && address == `REG_DAC_DATA0)) begin
              pending0 <= 1'b0;
            end
          end
          if (pending1) begin
            dac_output1 <= dac_data1;
            if (!(write_strobe && address == `REG_DAC_DATA1)) begin
              pending1 <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Destination gating: pin and comparator routes are independent.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dac_pin_enable0 <= 1'b0;
      dac_pin_enable1 <= 1'b0;
      dac_cmp_enable0 <= 1'b0;
      dac_cmp_enable1 <= 1'b0;
    end else if (clock_enable) begin
      dac_pin_enable0 <= dac_run && dac_control_register[`DAC_CONTROL_REGISTER_ENABLE0_BIT] &&
        dac_destination_register[`DSEL_PIN0_BIT];
      dac_pin_enable1 <= dac_run && dac_control_register[`DAC_CONTROL_REGISTER_ENABLE1_BIT] &&
        dac_destination_register[`DSEL_PIN1_BIT];
      dac_cmp_enable0 <= dac_run && dac_control_register[`DAC_CONTROL_REGISTER_ENABLE0_BIT] &&
        dac_destination_register[`DSEL_CMP0_BIT];
      dac_cmp_enable1 <= dac_run && dac_control_register[`DAC_CONTROL_REGISTER_ENABLE1_BIT] &&
        dac_destination_register[`DSEL_CMP1_BIT];
    end
  end

  // Read data stand in the cycle after the read strobe, and hold while clock_enable is low.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      read_data <= 16'h0000;
    end else if (clock_enable) begin
      read_data <= 16'h0000;
      if (read_strobe) begin
        case (address)
          `REG_INPUT_SELECT: read_data <= input_select_field[15:0];
          `REG_REFERENCE_SELECT: read_data <= reference_select_field[15:0];
          `REG_CMP_CONTROL: read_data <= {11'h000, channel_control[4:0]};
          `REG_CMP_RESULT: read_data <= {{16-CHANNELS{1'b0}},
            filtered & channel_valid};
          `REG_DAC_CONTROL: read_data <= {13'h0000, dac_control_register};
          `REG_DAC_DESTINATION: read_data <= {12'h000, dac_destination_register};
          `REG_DAC_DATA0: read_data <= {{16-DAC_BITS{1'b0}}, dac_data0};
          `REG_DAC_DATA1: read_data <= {{16-DAC_BITS{1'b0}}, dac_data1};
          `REG_STOP_CONTROL: read_data <= {14'h0000, stop_control};
          default: read_data <= 16'h0000;
        endcase
      end
    end
  end

endmodule // dac_comparator_control

`default_nettype wire

// ### verification/analog_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [23:0] input_connect,
  input wire logic [23:0] reference_connect,
  input wire logic [5:0] level,
  input wire logic allow,
  output logic [5:0] raw_result,
  output logic adc_sync_enable
);
  logic [2:0] phase;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) phase <= 3'h0;
    else phase <= phase + 3'h1;
  end
  // The converter side opens a one-cycle update window every eight cycles.
  assign adc_sync_enable = allow && phase == 3'h7;
  // A comparator with no input or no reference reads low.
  always_comb begin
    for (int n = 0; n < 6; n++) begin
      raw_result[n] = level[n] && |input_connect[4*n +: 4] && |reference_connect[4*n +: 4];
    end
  end
endmodule // analog_front_model
`default_nettype wire

// ### verification/dac_comparator_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmp_defines.vh"
module dac_comparator_control_sva #(
  parameter CHANNELS = 6,
  parameter DAC_BITS = 12
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clock_enable,
  input wire logic [3:0] address,
  input wire logic [15:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [15:0] read_data,
  input wire logic adc_stopped,
  input wire logic adc_sync_enable,
  input wire logic [4*CHANNELS-1:0] input_connect,
  input wire logic [CHANNELS-1:0] interrupt_request,
  input wire logic [CHANNELS-1:0] event_output,
  input wire logic [CHANNELS-1:0] output_enable_source,
  input wire logic [DAC_BITS-1:0] dac_output0,
  input wire logic dac_convert0
);
  logic [1:0] edge0;
  // Shadow of the channel 0 edge select.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      edge0 <= 2'h0;
    end else if (clock_enable && write_strobe && address == `REG_CMP_CONTROL) begin
      if (write_data[15:13] == 3'h0) edge0 <= write_data[3:2];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_rd_idle; clock_enable && !read_strobe |=> read_data == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read idle");
  property p_oe; output_enable_source == event_output; endproperty
  a_oe: assert property (p_oe) else $error("oe source");
  property p_onehot; $onehot0(input_connect[3:0]); endproperty
  a_onehot: assert property (p_onehot) else $error("input decode");
  property p_irq_edge; interrupt_request[0] |-> $changed(event_output[0]); endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("irq edge");
  property p_rise; edge0 == `EDGE_RISING && interrupt_request[0] |-> event_output[0]; endproperty
  a_rise: assert property (p_rise) else $error("rise only");
  property p_sync; $changed(dac_output0) |-> $past(adc_sync_enable); endproperty
  a_sync: assert property (p_sync) else $error("dac update");
  property p_conv; dac_convert0 |-> $past(adc_sync_enable) ##1 !dac_convert0; endproperty
  a_conv: assert property (p_conv) else $error("convert");
  property p_amp;
    adc_stopped && $past(adc_stopped) && input_connect[0] && $past(input_connect[0])
      |-> !event_output[0];
  endproperty
  a_amp: assert property (p_amp) else $error("amplified");
  c_irq: cover property (interrupt_request[0]);
  c_conv: cover property (dac_convert0);
  c_read: cover property (read_strobe ##1 read_data != 16'h0000);
endmodule // dac_comparator_control_sva
bind dac_comparator_control dac_comparator_control_sva #(.CHANNELS(CHANNELS),
  .DAC_BITS(DAC_BITS)) u_sva (.clock(clock), .rstn(rstn), .clock_enable(clock_enable),
  .address(address), .write_data(write_data), .write_strobe(write_strobe),
  .read_strobe(read_strobe), .read_data(read_data), .adc_stopped(adc_stopped),
  .adc_sync_enable(adc_sync_enable), .input_connect(input_connect),
  .interrupt_request(interrupt_request), .event_output(event_output),
  .output_enable_source(output_enable_source), .dac_output0(dac_output0),
  .dac_convert0(dac_convert0));
`default_nettype wire

// ### verification/tb_dac_comparator_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_cmp_defines.vh"
module tb_dac_comparator_control;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic ws = 1'b0;
  logic rs = 1'b0;
  logic stopped = 1'b0;
  logic ev = 1'b0;
  logic allow = 1'b0;
  logic [5:0] level = 6'h00;
  logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  wire [15:0] rdata;
  wire [5:0] raw, irq, evo, oes, pin, pin_en;
  wire [23:0] inc, refc;
  wire [11:0] dac0, dac1;
  wire pe0, pe1, cmp_en0, cmp_en1, conv, sync;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int pulses;
  always #50 clock = ~clock;
  dac_comparator_control u_dut (.clock(clock), .rstn(rstn), .clock_enable(ce), .address(addr),
    .write_data(wd), .write_strobe(ws), .read_strobe(rs), .read_data(rdata), .raw_result(raw),
    .adc_stopped(stopped), .adc_sync_enable(sync), .routed_event(ev), .input_connect(inc),
    .reference_connect(refc), .interrupt_request(irq), .event_output(evo),
    .output_enable_source(oes), .result_pin(pin), .result_pin_enable(pin_en),
    .dac_output0(dac0), .dac_output1(dac1), .dac_pin_enable0(pe0), .dac_pin_enable1(pe1),
    .dac_cmp_enable0(cmp_en0), .dac_cmp_enable1(cmp_en1), .dac_convert0(conv));
  analog_front_model u_model (.clock(clock), .rstn(rstn), .input_connect(inc),
    .reference_connect(refc), .level(level), .allow(allow), .raw_result(raw),
    .adc_sync_enable(sync));
  task automatic check(input string name, input logic [31:0] want, input logic [31:0] seen);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wd <= d;
    ws <= 1'b1;
    @(posedge clock);
    ws <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] want);
    @(posedge clock);
    addr <= a;
    rs <= 1'b1;
    @(posedge clock);
    rs <= 1'b0;
    #1;
    check("read_data", want, rdata);
  endtask
  // Counts high cycles of the channel 0 request or of the convert pulse.
  task automatic count(input int n, input bit sel);
    pulses = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if ((sel ? conv : irq[0]) === 1'b1) pulses++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    rd(`REG_STOP_CONTROL, 16'h0003);
    rd(4'hF, 16'h0000);
    wr(`REG_STOP_CONTROL, 16'h0000);
    $display("test reset done");
    foreach (codes[i]) begin
      wr(`REG_INPUT_SELECT, {12'h000, codes[i]});
      wr(`REG_REFERENCE_SELECT, {12'h000, codes[i]});
      rd(`REG_INPUT_SELECT, {12'h000, codes[i]});
      check("input_connect", codes[i], inc[3:0]);
      check("reference_connect", codes[i], refc[3:0]);
    end
    $display("test decode done");
    for (int e = 1; e < 4; e++) begin
      wr(`REG_CMP_CONTROL, {11'h000, 1'b1, e[1:0], 2'h0});
      @(posedge clock) level <= 6'h01;
      count(12, 1'b0);
      check("rise irq", e[0], pulses);
      check("event_output", 1, evo[0]);
      check("oe source", 1, oes[0]);
      check("result pin", 2'h3, {pin[0], pin_en[0]});
      rd(`REG_CMP_RESULT, 16'h0001);
      @(posedge clock) level <= 6'h00;
      count(12, 1'b0);
      check("fall irq", e[1], pulses);
    end
    $display("test edges done");
    wr(`REG_CMP_CONTROL, 16'h000F);
    @(posedge clock) level <= 6'h01;
    repeat (100) @(posedge clock);
    check("filter early", 0, evo[0]);
    for (int i = 0; i < 600 && evo[0] !== 1'b1; i++) @(posedge clock);
    check("filter late", 1, evo[0]);
    check("pin enable off", 0, pin_en[0]);
    $display("test filter done");
    wr(`REG_CMP_CONTROL, 16'h000C);
    wr(`REG_INPUT_SELECT, 16'h0001);
    @(posedge clock) stopped <= 1'b1;
    repeat (8) @(posedge clock);
    check("amplified stopped", 0, evo[0]);
    stopped <= 1'b0;
    repeat (8) @(posedge clock);
    check("amplified running", 1, evo[0]);
    $display("test amplifier done");
    wr(`REG_DAC_CONTROL, 16'h0007);
    wr(`REG_DAC_DESTINATION, 16'h0009);
    wr(`REG_DAC_DATA0, 16'h0FFF);
    repeat (2) @(posedge clock);
    check("destination", 4'h9, {cmp_en1, cmp_en0, pe1, pe0});
    wr(`REG_DAC_DESTINATION, 16'h0006);
    repeat (20) @(posedge clock);
    check("destination", 4'h6, {cmp_en1, cmp_en0, pe1, pe0});
    check("dac held", 0, dac0);
    allow <= 1'b1;
    repeat (20) @(posedge clock);
    check("dac0", 12'hFFF, dac0);
    wr(`REG_DAC_DATA1, 16'h0ABC);
    repeat (20) @(posedge clock);
    check("dac1", 12'hABC, dac1);
    ev <= 1'b1;
    @(posedge clock) ev <= 1'b0;
    count(20, 1'b1);
    check("convert", 1, pulses);
    $display("test converter done");
    @(posedge clock) ce <= 1'b0;
    wr(`REG_DAC_DATA1, 16'h0123);
    ce <= 1'b1;
    rd(`REG_DAC_DATA1, 16'h0ABC);
    wr(`REG_STOP_CONTROL, 16'h0002);
    repeat (3) @(posedge clock);
    check("dac stopped", 4'h0, {cmp_en1, cmp_en0, pe1, pe0});
    $display("test stop done");
    stop_test();
  end
endmodule // tb_dac_comparator_control
`default_nettype wire
